/* File: hw/temp_mon_pkg.sv */
// shared constants, register map and state types of the temperature monitor back end
package temp_mon_pkg;
  // clock and conversion timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CONV_SLOWEST_S = 16;
  localparam int unsigned CONV_SLOWEST_CYC = CONV_SLOWEST_S * CLK_HZ;
  // serial bus slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
  // register pointer values
  localparam logic [7:0] A_LOCAL = 8'h00;
  localparam logic [7:0] A_REM_HI = 8'h01;
  localparam logic [7:0] A_STATUS = 8'h02;
  localparam logic [7:0] A_CFG_RD = 8'h03;
  localparam logic [7:0] A_RATE_RD = 8'h04;
  localparam logic [7:0] A_CFG_WR = 8'h09;
  localparam logic [7:0] A_RATE_WR = 8'h0A;
  localparam logic [7:0] A_REM_LO = 8'h10;
  localparam logic [7:0] A_LIM_BASE = 8'h20;
  localparam logic [7:0] A_LIM_LAST = 8'h25;
  // limit array slots: local high, low, overtemp_output, remote high, low, overtemp_output
  localparam int LIM_NUM = 6;
  localparam int LIM_LH = 0;
  localparam int LIM_LL = 1;
  localparam int LIM_LT = 2;
  localparam int LIM_RH = 3;
  localparam int LIM_RL = 4;
  localparam int LIM_RT = 5;
  localparam logic [7:0] LIM_RST [0:LIM_NUM-1] = '{8'h55, 8'h00, 8'h55, 8'h55, 8'h00, 8'h55};
  // configuration fields
  localparam int CFG_RANGE = 2;
  localparam int CFG_PIN_MODE = 5;
  localparam int CFG_STOP = 6;
  localparam int CFG_MASK = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CFG_WR_MASK = 8'hE4;
  // conversion rate field
  localparam logic [7:0] RATE_RST = 8'h08;
  localparam logic [7:0] RATE_WR_MASK = 8'h0F;
  localparam logic [3:0] RATE_MAX = 4'hA;
  localparam logic [3:0] RATE_NO_AVG = 4'h8;
  localparam logic [3:0] AVG_LAST = 4'hF;
  // status bit positions
  localparam int ST_LTHERM = 0;
  localparam int ST_RTHERM = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_RLOW = 3;
  localparam int ST_RHIGH = 4;
  localparam int ST_LLOW = 5;
  localparam int ST_LHIGH = 6;
  // result coding, values in quarter degrees
  localparam logic signed [12:0] EXT_OFFSET_Q = 13'sh0100;
  localparam logic [9:0] CODE_MAX_BIN = 10'h1FF;
  localparam logic [9:0] CODE_MAX_EXT = 10'h3FF;
  // state types
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK
  } bus_state_t;
  typedef enum logic [1:0] {CV_IDLE, CV_LOCAL, CV_REMOTE} conv_state_t;
endpackage

/* File: hw/temp_code_formatter.sv */
// converts a signed quarter-degree result into plain or offset binary with clamping
`timescale 1ns/1ns
module temp_code_formatter (
  // raw result and range select
  input wire logic signed [11:0] i_quarters,
  input wire logic i_ext_range,
  // integer byte in [9:2], half and quarter degree in [1:0]
  output logic [9:0] o_code
);
  logic signed [12:0] shifted;
  logic [9:0] code_max;

  // offset by 64 degrees in extended range, then clamp to the range ends
  always_comb begin
    shifted = {i_quarters[11], i_quarters};
    code_max = temp_mon_pkg::CODE_MAX_BIN;
    if (i_ext_range) begin
      shifted = shifted + temp_mon_pkg::EXT_OFFSET_Q; // [R15]
      code_max = temp_mon_pkg::CODE_MAX_EXT;
    end
    if (shifted < 13'sh0000) begin
      o_code = 10'h000; // [R16]
    end else if (shifted > $signed({3'h0, code_max})) begin
      o_code = code_max; // [R16]
    end else begin
      o_code = shifted[9:0];
    end
  end
endmodule

/* File: hw/temp_monitor_core.sv */
// digital back end of a dual channel temperature monitor with a two-wire register port
//
// Summary of operation
// R1 - converter free runs, alternating local and remote, storing each result.
// R2 - results compared with high, low and over-temperature limits; flags in status.
// R3 - above high or at/below low limit asserts alarm when pin is in alarm mode.
// R4 - a remote diode fault also asserts the alarm output.
// R5 - either result above its over-temperature limit drives the over-temp output low.
// R6 - software may switch the alarm pin into a second over-temperature output.
// R7 - slow rates store the average of sixteen measurements; 16/32/64 per second don't.
// R8 - local result is one byte at pointer 0x00, one degree per step.
// R9 - remote result is high byte 0x01 and low byte 0x10, quarter degree steps.
// R10 - remote low byte: bit 7 half degree, bit 6 quarter, other bits zero.
// R11 - reading the remote low byte first freezes the high byte until it is read.
// R12 - configuration bit 2 selects 0..127 or extended -64..191 degree range.
// R13 - after a range change the next measurement gives a result in the new range.
// R14 - on a shorted remote diode the remote result keeps the last good value.
// R15 - plain binary in default range, offset binary (+64) in extended range.
// R16 - in plain binary, below zero reads 0 and above 127 reads 127.
// R17 - range may switch anytime; next result uses new format, limits untouched.
// R18 - host rewrites limits in the new format after a range change.
// R19 - every register readable; limits and configuration writable over the bus.
// R20 - first byte of a write loads the pointer; later bytes and reads use it.
// R21 - configuration is read at 0x03 and written at 0x09.
// R22 - while frozen, new remote results do not reach the high byte; high read releases.
`timescale 1ns/1ns
module temp_monitor_core #(
  parameter int unsigned P_CONV_SLOWEST_CYC = temp_mon_pkg::CONV_SLOWEST_CYC,
  parameter logic [6:0] P_DEV_ADDR = temp_mon_pkg::DEV_ADDR_DEF
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // two-wire bus pins, data driven low while o_sda_oe is high
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // converter handshake
  output logic o_conv_start,
  output logic o_conv_remote,
  input wire logic i_conv_done,
  input wire logic signed [11:0] i_conv_sample,
  input wire logic i_diode_fault,
  // open-drain outputs, pin pulled low while enable is high
  output logic o_alarm_oe,
  output logic o_overtemp_oe
);
  // pin synchronisers; stage 3 only feeds edge detection
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {i_scl, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {i_sda, sda_s1_q, sda_s2_q};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // bus slave and register state
  temp_mon_pkg::bus_state_t bus_st_q, bus_st_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d, cfg_q, cfg_d, rate_q, rate_d;
  logic rw_q, rw_d, first_q, first_d, sda_oe_q, sda_oe_d, freeze_q, freeze_d;
  logic [7:0] lim_q [0:temp_mon_pkg::LIM_NUM-1];
  logic [7:0] lim_d [0:temp_mon_pkg::LIM_NUM-1];
  logic load_rd;
  logic [7:0] rd_byte;

  // core state
  temp_mon_pkg::conv_state_t cv_st_q, cv_st_d;
  logic [31:0] timer_q, timer_d, period;
  logic [3:0] n_q, n_d, rate_code, last_n;
  logic signed [15:0] sum_q, sum_d, total;
  logic seen_flt_q, seen_flt_d, start_q, start_d, remote_q, remote_d;
  logic [7:0] l_code_q, l_code_d, r_hi_q, r_hi_d, status_q, status_d;
  logic [9:0] r_val_q, r_val_d, fmt_code;
  logic [1:0] r_lo_q, r_lo_d;
  logic fault_q, fault_d, alarm_q, alarm_d, overtemp_output_q, overtemp_output_d, store_l, store_r;
  logic signed [11:0] avg_q4;

  // read multiplexer over the pointer [R19] [R8] [R9] [R21]
  always_comb begin
    unique case (ptr_q)
      temp_mon_pkg::A_LOCAL: rd_byte = l_code_q;
      temp_mon_pkg::A_REM_HI: rd_byte = r_hi_q;
      temp_mon_pkg::A_REM_LO: rd_byte = {r_lo_q, 6'h00}; // [R10]
      temp_mon_pkg::A_STATUS: rd_byte = status_q;
      temp_mon_pkg::A_CFG_RD: rd_byte = cfg_q;
      temp_mon_pkg::A_RATE_RD: rd_byte = rate_q;
      default: begin
        if (ptr_q >= temp_mon_pkg::A_LIM_BASE && ptr_q <= temp_mon_pkg::A_LIM_LAST) begin
          rd_byte = lim_q[3'(ptr_q - temp_mon_pkg::A_LIM_BASE)];
        end else begin
          rd_byte = 8'h00; // unmapped pointer reads zero
        end
      end
    endcase
  end

  // bus slave: bits sampled on scl rise, data changed only on scl fall
  always_comb begin
    bus_st_d = bus_st_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    cfg_d = cfg_q;
    rate_d = rate_q;
    rw_d = rw_q;
    first_d = first_q;
    sda_oe_d = sda_oe_q;
    freeze_d = freeze_q;
    lim_d = lim_q;
    load_rd = 1'b0;
    if (bus_stop) begin
      bus_st_d = temp_mon_pkg::BUS_IDLE;
      sda_oe_d = 1'b0;
    end else if (bus_start) begin
      bus_st_d = temp_mon_pkg::BUS_ADDR;
      bit_cnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      unique case (bus_st_q)
        temp_mon_pkg::BUS_IDLE: ;
        temp_mon_pkg::BUS_ADDR, temp_mon_pkg::BUS_WR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s2_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            sda_oe_d = 1'b1; // acknowledge
            if (bus_st_q == temp_mon_pkg::BUS_WR) begin
              bus_st_d = temp_mon_pkg::BUS_WR_ACK;
              first_d = 1'b0;
              if (first_q) begin
                ptr_d = shift_q; // [R20]
              end else if (ptr_q == temp_mon_pkg::A_CFG_WR) begin
                cfg_d = shift_q & temp_mon_pkg::CFG_WR_MASK; // [R21] [R12]
              end else if (ptr_q == temp_mon_pkg::A_RATE_WR) begin
                rate_d = shift_q & temp_mon_pkg::RATE_WR_MASK; // [R19]
              end else if (ptr_q >= temp_mon_pkg::A_LIM_BASE &&
                           ptr_q <= temp_mon_pkg::A_LIM_LAST) begin
                lim_d[3'(ptr_q - temp_mon_pkg::A_LIM_BASE)] = shift_q; // [R19]
              end
            end else if (shift_q[7:1] == P_DEV_ADDR) begin
              bus_st_d = temp_mon_pkg::BUS_ADDR_ACK;
              rw_d = shift_q[0];
            end else begin
              bus_st_d = temp_mon_pkg::BUS_IDLE; // not ours, stay off the line
              sda_oe_d = 1'b0;
            end
          end
        end
        temp_mon_pkg::BUS_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_d = 4'h0;
            first_d = 1'b1;
            sda_oe_d = 1'b0;
            bus_st_d = temp_mon_pkg::BUS_WR;
            load_rd = rw_q;
          end
        end
        temp_mon_pkg::BUS_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            bit_cnt_d = 4'h0;
            bus_st_d = temp_mon_pkg::BUS_WR;
          end
        end
        temp_mon_pkg::BUS_RD: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              sda_oe_d = 1'b0;
              bus_st_d = temp_mon_pkg::BUS_RD_ACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_d = ~shift_q[6];
            end
          end
        end
        temp_mon_pkg::BUS_RD_ACK: begin
          if (scl_rise && sda_s2_q) begin
            bus_st_d = temp_mon_pkg::BUS_IDLE; // master ended the read
          end else if (scl_fall) begin
            load_rd = 1'b1; // same pointer again, no auto increment
          end
        end
      endcase
    end
    // start a read byte; low byte read locks the high byte [R11] [R22]
    if (load_rd) begin
      bus_st_d = temp_mon_pkg::BUS_RD;
      bit_cnt_d = 4'h0;
      shift_d = rd_byte;
      sda_oe_d = ~rd_byte[7];
      if (ptr_q == temp_mon_pkg::A_REM_LO) begin
        freeze_d = 1'b1; // [R11]
      end else if (ptr_q == temp_mon_pkg::A_REM_HI) begin
        freeze_d = 1'b0; // [R22]
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_st_q <= temp_mon_pkg::BUS_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= temp_mon_pkg::A_LOCAL;
      cfg_q <= temp_mon_pkg::CFG_RST;
      rate_q <= temp_mon_pkg::RATE_RST;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sda_oe_q <= 1'b0;
      freeze_q <= 1'b0;
      lim_q <= temp_mon_pkg::LIM_RST;
    end else begin
      bus_st_q <= bus_st_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      cfg_q <= cfg_d;
      rate_q <= rate_d;
      rw_q <= rw_d;
      first_q <= first_d;
      sda_oe_q <= sda_oe_d;
      freeze_q <= freeze_d;
      lim_q <= lim_d;
    end
  end

  // reserved rate codes run at the fastest rate
  assign rate_code = (rate_q[3:0] > temp_mon_pkg::RATE_MAX) ? temp_mon_pkg::RATE_MAX : rate_q[3:0];
  assign period = 32'(P_CONV_SLOWEST_CYC >> rate_code);
  assign last_n = (rate_code < temp_mon_pkg::RATE_NO_AVG) ? temp_mon_pkg::AVG_LAST : 4'h0; // [R7]
  assign total = sum_q + 16'(i_conv_sample);
  // sixteen samples divide by shifting; a single sample passes unchanged [R7]
  assign avg_q4 = (last_n == temp_mon_pkg::AVG_LAST) ? total[15:4] : total[11:0];
  assign store_l = (cv_st_q == temp_mon_pkg::CV_LOCAL) && i_conv_done && n_q == last_n;
  assign store_r = (cv_st_q == temp_mon_pkg::CV_REMOTE) && i_conv_done && n_q == last_n;

  // range bit is taken at store time, so the next result follows a switch [R13] [R17]
  temp_code_formatter u_fmt (
    .i_quarters(avg_q4),
    .i_ext_range(cfg_q[temp_mon_pkg::CFG_RANGE]),
    .o_code(fmt_code)
  );

  // conversion sequencing, result store and limit comparison
  always_comb begin
    cv_st_d = cv_st_q;
    n_d = n_q;
    sum_d = sum_q;
    seen_flt_d = seen_flt_q;
    start_d = 1'b0;
    remote_d = remote_q;
    l_code_d = l_code_q;
    r_val_d = r_val_q;
    fault_d = fault_q;
    timer_d = (timer_q == 32'h0) ? period - 32'h1 : timer_q - 32'h1;
    unique case (cv_st_q)
      temp_mon_pkg::CV_IDLE: begin
        if (timer_q == 32'h0 && !cfg_q[temp_mon_pkg::CFG_STOP]) begin
          cv_st_d = temp_mon_pkg::CV_LOCAL; // [R1]
          start_d = 1'b1;
          remote_d = 1'b0;
          n_d = 4'h0;
          sum_d = 16'sh0000;
        end
      end
      temp_mon_pkg::CV_LOCAL, temp_mon_pkg::CV_REMOTE: begin
        if (i_conv_done) begin
          start_d = 1'b1;
          n_d = n_q + 4'h1;
          sum_d = total;
          seen_flt_d = seen_flt_q | (remote_q & i_diode_fault);
          if (store_l) begin
            l_code_d = fmt_code[9:2]; // [R8] [R1]
            cv_st_d = temp_mon_pkg::CV_REMOTE;
            remote_d = 1'b1;
            n_d = 4'h0;
            sum_d = 16'sh0000;
            seen_flt_d = 1'b0;
          end else if (store_r) begin
            start_d = 1'b0;
            cv_st_d = temp_mon_pkg::CV_IDLE;
            fault_d = seen_flt_q | i_diode_fault;
            if (!(seen_flt_q | i_diode_fault)) begin
              r_val_d = fmt_code; // [R9] [R1]
            end // a faulty diode leaves the last good result [R14]
          end
        end
      end
    endcase
    // lagging copies keep both bytes from one result; high byte waits while frozen
    // it also holds in the low read's own cycle, so a result landing then cannot split the pair
    r_lo_d = r_val_q[1:0];
    r_hi_d = (freeze_q | freeze_d) ? r_hi_q : r_val_q[9:2]; // [R22]
    // comparisons run continuously, so limit or mode changes in standby act too [R2]
    status_d = 8'h00;
    status_d[temp_mon_pkg::ST_LHIGH] = l_code_q > lim_q[temp_mon_pkg::LIM_LH];
    status_d[temp_mon_pkg::ST_LLOW] = l_code_q <= lim_q[temp_mon_pkg::LIM_LL];
    status_d[temp_mon_pkg::ST_LTHERM] = l_code_q > lim_q[temp_mon_pkg::LIM_LT];
    status_d[temp_mon_pkg::ST_RHIGH] = r_val_q > {lim_q[temp_mon_pkg::LIM_RH], 2'h0};
    status_d[temp_mon_pkg::ST_RLOW] = r_val_q <= {lim_q[temp_mon_pkg::LIM_RL], 2'h0};
    status_d[temp_mon_pkg::ST_RTHERM] = r_val_q > {lim_q[temp_mon_pkg::LIM_RT], 2'h0};
    status_d[temp_mon_pkg::ST_FAULT] = fault_q;
    overtemp_output_d = status_d[temp_mon_pkg::ST_LTHERM] | status_d[temp_mon_pkg::ST_RTHERM]; // [R5]
    if (cfg_q[temp_mon_pkg::CFG_PIN_MODE]) begin
      alarm_d = status_d[temp_mon_pkg::ST_LHIGH] | status_d[temp_mon_pkg::ST_RHIGH]; // [R6]
    end else begin
      alarm_d = ~cfg_q[temp_mon_pkg::CFG_MASK] & (|status_d[6:2]); // [R3] [R4]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cv_st_q <= temp_mon_pkg::CV_IDLE;
      timer_q <= 32'h0;
      n_q <= 4'h0;
      sum_q <= 16'sh0000;
      seen_flt_q <= 1'b0;
      start_q <= 1'b0;
      remote_q <= 1'b0;
      l_code_q <= 8'h00;
      r_val_q <= 10'h000;
      r_hi_q <= 8'h00;
      r_lo_q <= 2'h0;
      fault_q <= 1'b0;
      status_q <= 8'h00;
      alarm_q <= 1'b0;
      overtemp_output_q <= 1'b0;
    end else begin
      cv_st_q <= cv_st_d;
      timer_q <= timer_d;
      n_q <= n_d;
      sum_q <= sum_d;
      seen_flt_q <= seen_flt_d;
      start_q <= start_d;
      remote_q <= remote_d;
      l_code_q <= l_code_d;
      r_val_q <= r_val_d;
      r_hi_q <= r_hi_d;
      r_lo_q <= r_lo_d;
      fault_q <= fault_d;
      status_q <= status_d;
      alarm_q <= alarm_d;
      overtemp_output_q <= overtemp_output_d;
    end
  end

  assign o_sda_out = 1'b0 & sda_oe_q; // open drain: only ever pulls low
  assign o_sda_oe = sda_oe_q;
  assign o_conv_start = start_q;
  assign o_conv_remote = remote_q;
  assign o_alarm_oe = alarm_q;
  assign o_overtemp_oe = overtemp_output_q;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  chk_alarm_limit: assert property ( // [R3]
    (!cfg_q[temp_mon_pkg::CFG_PIN_MODE] && !cfg_q[temp_mon_pkg::CFG_MASK] &&
     r_val_q > {lim_q[temp_mon_pkg::LIM_RH], 2'h0}) |=> o_alarm_oe)
    else $error("alarm missing for remote high");
  chk_alarm_fault: assert property ( // [R4]
    (store_r && i_diode_fault && cfg_q == 8'h00) ##1 (cfg_q == 8'h00) |-> ##1 o_alarm_oe)
    else $error("alarm missing on diode fault");
  chk_overtemp_low: assert property ( // [R5]
    (l_code_q > lim_q[temp_mon_pkg::LIM_LT]) |=> o_overtemp_oe)
    else $error("over-temp output not driven");
  chk_second_overtemp_output: assert property ( // [R6]
    (cfg_q[temp_mon_pkg::CFG_PIN_MODE] && l_code_q <= lim_q[temp_mon_pkg::LIM_LH] &&
     r_val_q <= {lim_q[temp_mon_pkg::LIM_RH], 2'h0}) [*2] |-> !o_alarm_oe)
    else $error("second over-temp output active without cause");
  chk_fault_hold: assert property ( // [R14]
    (store_r && i_diode_fault) |=> $stable(r_val_q))
    else $error("remote result changed on faulty diode");
  chk_freeze_hold: assert property ( // [R22]
    freeze_q |=> $stable(r_hi_q))
    else $error("frozen high byte changed");
  chk_low_bits: assert property ( // [R10]
    (load_rd && ptr_q == temp_mon_pkg::A_REM_LO) |=> shift_q[5:0] == 6'h00)
    else $error("remote low byte unused bits not zero");
  chk_clamp_bin: assert property ( // [R16]
    (store_l && !cfg_q[temp_mon_pkg::CFG_RANGE]) |=> l_code_q <= 8'h7F)
    else $error("plain binary result above 127");
  chk_standby_idle: assert property ( // [R1]
    (cv_st_q == temp_mon_pkg::CV_IDLE && cfg_q[temp_mon_pkg::CFG_STOP]) |=> !o_conv_start)
    else $error("conversion started in standby");
endmodule

/* File: tb/smbus_host_model.sv */
// two-wire bus host model that writes and reads device registers
`timescale 1ns/1ns
module smbus_host_model #(
  parameter logic [6:0] P_ADDR = 7'h2A
) (
  // pacing clock
  input wire logic i_clk_sys,
  // data level on the wire, pulled up when released
  input wire logic i_sda,
  // clock pin and data pull-down enable
  output logic o_scl,
  output logic o_sda_oe
);
  int nak_cnt = 0;
  // idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // every change lands just after a clock edge
  task automatic hc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // ten cycles high and low keeps well above the device's minimum
  task automatic bit_x(input logic v, output logic r);
    o_sda_oe = !v;
    hc(5);
    o_scl = 1'b1;
    hc(5);
    r = i_sda;
    hc(5);
    o_scl = 1'b0;
    hc(5);
  endtask
  // also serves as repeated start
  task automatic start_c;
    o_sda_oe = 1'b0;
    hc(3);
    o_scl = 1'b1;
    hc(5);
    o_sda_oe = 1'b1;
    hc(5);
    o_scl = 1'b0;
    hc(5);
  endtask
  task automatic stop_c;
    o_sda_oe = 1'b1;
    hc(5);
    o_scl = 1'b1;
    hc(5);
    o_sda_oe = 1'b0;
    hc(10);
  endtask
  // byte out msb first, a missing ack is counted
  task automatic put_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    if (r !== 1'b0) nak_cnt++;
  endtask
  // byte in, then nack to end the read
  task automatic get_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(1'b1, r);
  endtask
  // first byte after the address loads the pointer
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    start_c;
    put_byte({P_ADDR, 1'b0});
    put_byte(p);
    put_byte(d);
    stop_c;
  endtask
  // pointer write, repeated start, one byte read
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    start_c;
    put_byte({P_ADDR, 1'b0});
    put_byte(p);
    start_c;
    put_byte({P_ADDR, 1'b1});
    get_byte(d);
    stop_c;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the temperature monitor back end
`timescale 1ns/1ns
module testbench;
  localparam int unsigned SLOW = 4096;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic scl, host_oe, sda_out, sda_oe, start, remote, alarm, otemp, ch;
  logic done = 1'b0;
  logic fault = 1'b0;
  logic flt = 1'b0;
  logic alt = 1'b0;
  logic tog = 1'b0;
  logic [11:0] sample = 12'h000;
  logic [11:0] loc_q = 12'h000;
  logic [11:0] rem_q = 12'h000;
  int error_cnt = 0;
  int n_checks = 0;
  wire sda_w = !(host_oe || sda_oe);
  always #50 clk_sys = !clk_sys;
  temp_monitor_core #(.P_CONV_SLOWEST_CYC(SLOW)) i_temp_monitor_core (.i_clk_sys(clk_sys),
    .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_conv_start(start), .o_conv_remote(remote), .i_conv_done(done),
    .i_conv_sample(sample), .i_diode_fault(fault), .o_alarm_oe(alarm),
    .o_overtemp_oe(otemp));
  smbus_host_model i_smbus_host_model (.i_clk_sys(clk_sys), .i_sda(sda_w), .o_scl(scl),
    .o_sda_oe(host_oe));
  // converter: answers each start three cycles later; alt swings local samples by 2 degrees
  always begin
    @(posedge clk_sys);
    #1;
    while (start === 1'b1) begin
      ch = remote;
      repeat (3) @(posedge clk_sys);
      #1;
      sample = ch ? rem_q : loc_q + ((alt && tog) ? 12'h008 : 12'h000);
      fault = ch & flt;
      done = 1'b1;
      tog = !tog;
      @(posedge clk_sys);
      #1;
      done = 1'b0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_smbus_host_model.wr_reg(p, d);
    cyc(5);
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] exp, input string what);
    logic [7:0] v;
    i_smbus_host_model.rd_reg(p, v);
    chk(v, exp, what);
  endtask
  // 80 cycles covers several local and remote pairs at the fast rate
  task automatic t_format;
    logic [11:0] tq [5] = '{12'hFD8, 12'h0C8, 12'h208, 12'hF24, 12'h258};
    logic [7:0] ex [5] = '{8'h00, 8'h32, 8'h7F, 8'h09, 8'hD6};
    for (int i = 0; i < 5; i++) begin
      if (i == 3) begin
        wr(temp_mon_pkg::A_CFG_WR, 8'h04);
        rdc(temp_mon_pkg::A_CFG_RD, 8'h04, "range bit");
        rdc(temp_mon_pkg::A_LIM_BASE + 8'h03, 8'h55, "limit kept");
        wr(temp_mon_pkg::A_LIM_BASE, 8'h95);
      end
      loc_q = tq[i];
      cyc(80);
      rdc(temp_mon_pkg::A_LOCAL, ex[i], "local code");
    end
    wr(temp_mon_pkg::A_CFG_WR, 8'h00);
    wr(temp_mon_pkg::A_LIM_BASE, 8'h55);
    rdc(8'h30, 8'h00, "unmapped");
  endtask
  task automatic t_remote;
    // local inside its limits, so only the diode fault can raise the alarm below
    loc_q = 12'h0C8;
    rem_q = 12'h067;
    cyc(80);
    rdc(temp_mon_pkg::A_REM_LO, 8'hC0, "remote low");
    rem_q = 12'h078;
    cyc(80);
    rdc(temp_mon_pkg::A_REM_HI, 8'h19, "frozen high");
    cyc(80);
    rdc(temp_mon_pkg::A_REM_HI, 8'h1E, "released high");
    flt = 1'b1;
    rem_q = 12'h168;
    cyc(80);
    rdc(temp_mon_pkg::A_REM_HI, 8'h1E, "last good");
    chk({7'h00, alarm}, 8'h01, "fault alarm");
    flt = 1'b0;
    rem_q = 12'h078;
  endtask
  task automatic t_limits;
    loc_q = 12'h0C8;
    cyc(80);
    chk({7'h00, alarm}, 8'h00, "alarm idle");
    wr(temp_mon_pkg::A_LIM_BASE + 8'h03, 8'h14);
    chk({7'h00, alarm}, 8'h01, "remote high");
    wr(temp_mon_pkg::A_LIM_BASE + 8'h03, 8'h55);
    wr(temp_mon_pkg::A_LIM_BASE, 8'h28);
    chk({7'h00, alarm}, 8'h01, "alarm high");
    rdc(temp_mon_pkg::A_STATUS, 8'h40, "status");
    wr(temp_mon_pkg::A_LIM_BASE + 8'h02, 8'h2D);
    chk({7'h00, otemp}, 8'h01, "over-temp");
    wr(temp_mon_pkg::A_CFG_WR, 8'h80);
    chk({7'h00, alarm}, 8'h00, "masked");
    wr(temp_mon_pkg::A_CFG_WR, 8'hA0);
    chk({7'h00, alarm}, 8'h01, "second over-temp");
    wr(temp_mon_pkg::A_LIM_BASE, 8'h55);
    chk({7'h00, alarm}, 8'h00, "second over-temp off");
    wr(temp_mon_pkg::A_CFG_WR, 8'h00);
    wr(temp_mon_pkg::A_LIM_BASE + 8'h02, 8'h55);
    rdc(temp_mon_pkg::A_LIM_BASE + 8'h02, 8'h55, "limit back");
    chk({7'h00, otemp}, 8'h00, "over-temp off");
    // standby: a new local temperature must not reach the register until running again
    wr(temp_mon_pkg::A_CFG_WR, 8'h40);
    loc_q = 12'h190;
    cyc(80);
    rdc(temp_mon_pkg::A_LOCAL, 8'h32, "standby holds");
    wr(temp_mon_pkg::A_CFG_WR, 8'h00);
    cyc(80);
    rdc(temp_mon_pkg::A_LOCAL, 8'h64, "running again");
  endtask
  // slowest rate: 16 samples of 100 and 102 degrees average to 101
  task automatic t_avg;
    wr(temp_mon_pkg::A_RATE_WR, 8'h00);
    rdc(temp_mon_pkg::A_RATE_RD, 8'h00, "rate");
    alt = 1'b1;
    loc_q = 12'h190;
    cyc(2 * SLOW + 400);
    rdc(temp_mon_pkg::A_LOCAL, 8'h65, "averaged");
    alt = 1'b0;
    wr(temp_mon_pkg::A_RATE_WR, 8'h08);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(5);
    t_format;
    t_remote;
    t_limits;
    t_avg;
    chk({7'h00, sda_out}, 8'h00, "sda level");
    chk(i_smbus_host_model.nak_cnt[7:0], 8'h00, "acks");
    end_sim;
  end
  // the sequence needs about 33400 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    end_sim;
  end
endmodule
